// >>> src/islmc_pkg.sv
package islmc_pkg;
    // serial word layout
    localparam int WORD_BITS = 8;            // bits per companded word
    localparam int RISES_PER_BIT = 2;        // each bit spans two data clock periods
    localparam int SLOT_RISES = WORD_BITS * RISES_PER_BIT;
    // rising edge indices within a frame, edge 0 is the frame start edge
    localparam logic [5:0] FIRST_SLOT_BASE = 6'h00;   // first bearer slot starts here
    localparam logic [5:0] SECOND_SLOT_BASE = 6'h10;  // second bearer slot starts here
    localparam logic [5:0] SLOT_LAST_OFS = 6'h0f;     // last rising edge inside a slot
    localparam logic [5:0] FRAME_END_RISE = 6'h20;    // frame finished after this edge
    localparam logic [5:0] RISE_CNT_MAX = 6'h3f;      // counter saturation
    // code word fields
    localparam int SIGN_POS = 7;             // sign bit, transmitted first
    localparam int CHORD_MSB = 6;            // three-bit chord field
    localparam int CHORD_LSB = 4;
    localparam int STEP_MSB = 3;             // four-bit step field
    localparam int STEP_LSB = 0;
    // linear sample format and companding constants
    localparam int SAMPLE_W = 14;            // signed linear sample
    localparam int MAG_W = 13;               // magnitude width
    localparam logic [13:0] MAG_MAX = 14'h1fdf;     // top decision level, 8159
    localparam logic [13:0] MULAW_BIAS = 14'h0021;  // bias of 33
    localparam logic [13:0] BIASED_MAX = 14'h1fff;  // biased magnitude ceiling
    localparam logic [13:0] DEC_STEP_BASE = 14'h0020; // bias less one, 32
    localparam int CHORD_BASE_BIT = 5;       // lowest bit that names chord 0
    localparam int CHORDS = 8;
    // frame sequencer states
    typedef enum logic [2:0] {
        ISLMC_IDLE = 3'b001,
        ISLMC_ARMED = 3'b010,
        ISLMC_FRAME = 3'b100
    } islmc_state_e;
endpackage : islmc_pkg

// >>> src/islmc_mulaw.sv
`timescale 1ns/100ps
// combinational mu-law compander, encoder and decoder share one table
module islmc_mulaw
    import islmc_pkg::*;
(
    input wire logic [SAMPLE_W-1:0] enc_sample_in,
    output logic [WORD_BITS-1:0] enc_code_out,
    input wire logic [WORD_BITS-1:0] dec_code_in,
    output logic [SAMPLE_W-1:0] dec_sample_out
);

    // linear to code: bias, find chord, take four step bits, invert magnitude
    function automatic logic [WORD_BITS-1:0] mulaw_encode(input logic [SAMPLE_W-1:0] s);
        logic negative;
        logic [13:0] mag;
        logic [13:0] biased;
        logic [2:0] chord;
        logic [13:0] shifted;
        negative = s[SAMPLE_W-1];
        mag = negative ? (~s + 14'h0001) : s;
        chord = 3'h0;
        if (mag > MAG_MAX) begin
            mag = MAG_MAX; // clip at top decision level
        end
        biased = mag + MULAW_BIAS;
        if (biased > BIASED_MAX) begin
            biased = BIASED_MAX;
        end
        for (int i = 0; i < CHORDS; i++) begin
            if (biased[i + CHORD_BASE_BIT]) begin
                chord = 3'(i); // highest set bit wins
            end
        end
        shifted = biased >> (4'({1'b0, chord}) + 4'h1);
        // positive is sign 1, negative sign 0, same magnitude bits
        mulaw_encode = {~negative, ~chord, ~shifted[3:0]};
    endfunction : mulaw_encode

    // code to linear: decode level at the centre of the step
    function automatic logic [SAMPLE_W-1:0] mulaw_decode(input logic [WORD_BITS-1:0] c);
        logic [2:0] chord;
        logic [3:0] step;
        logic [13:0] level;
        chord = ~c[CHORD_MSB:CHORD_LSB];
        step = ~c[STEP_MSB:STEP_LSB];
        level = ((14'({step, 1'b1}) + DEC_STEP_BASE) << chord) - MULAW_BIAS;
        mulaw_decode = c[SIGN_POS] ? level : (~level + 14'h0001);
    endfunction : mulaw_decode

    // both directions purely combinational
    always_comb begin
        enc_code_out = mulaw_encode(enc_sample_in);
        dec_sample_out = mulaw_decode(dec_code_in);
    end

endmodule : islmc_mulaw

// >>> src/islmc_port.sv
`timescale 1ns/100ps
module islmc_port
    import islmc_pkg::*;
#(
    parameter int BITS_PER_WORD = WORD_BITS // serial word length
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic slot_data_clock_in,    // data clock from the master
    input wire logic frame_sync_pulse_in,   // frame sync from the master
    input wire logic serial_data_in,        // received serial bits
    input wire logic second_bearer_slot_in, // 1 selects second bearer slot
    input wire logic [SAMPLE_W-1:0] tx_sample_in, // linear sample to send
    output logic serial_data_out,           // transmitted bit
    output logic serial_data_oe_out,        // high while driving the pin
    output logic tx_sample_taken_out,       // pulse when sample is latched
    output logic [SAMPLE_W-1:0] rx_sample_out, // decoded received sample
    output logic [WORD_BITS-1:0] rx_code_out,  // raw received code
    output logic rx_valid_out               // pulse when a word arrived
);

    // compander datapath is fixed at eight bits
    // any other word length is refused at elaboration
    if (BITS_PER_WORD != WORD_BITS) begin : g_word_check
        // a wider word would need a wider compander table
        $error("islmc_port supports only eight-bit words");
    end

    logic dcl_s1_r, dcl_s2_r, dcl_d_r;   // data clock synchroniser and history
    logic fsc_s1_r, fsc_s2_r, fsc_d_r;   // frame sync synchroniser and history
    logic din_s1_r, din_s2_r;            // serial input synchroniser
    islmc_state_e state_r;               // frame sequencer state
    logic [5:0] rise_cnt_r;              // rising edges since frame start
    logic slot_sel_r;                    // slot chosen for this frame
    logic confirmed_r;                   // sync seen high at a falling edge
    logic [WORD_BITS-1:0] tx_shift_r;    // outgoing code, msb first
    logic [WORD_BITS-2:0] rx_shift_r;    // incoming bits so far
    logic drive_r;                       // output enable
    logic taken_r, rx_valid_r;           // one-cycle pulses
    logic [SAMPLE_W-1:0] rx_sample_r;    // decoded word
    logic [WORD_BITS-1:0] rx_code_r;     // raw received word
    logic [WORD_BITS-1:0] enc_code;      // encoder result
    logic [WORD_BITS-1:0] rx_word;       // word completed this edge
    logic [SAMPLE_W-1:0] dec_sample;     // decoder result
    logic dcl_rise, dcl_fall, fsc_rise;  // edge events
    logic start, edge_evt;               // frame start, any counted rise
    logic [5:0] idx, base, rel, fall_rel;

    // three pins cross into the core clock domain through two flops each
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dcl_s1_r <= 1'b0;
            dcl_s2_r <= 1'b0;
            dcl_d_r <= 1'b0;
            fsc_s1_r <= 1'b0;
            fsc_s2_r <= 1'b0;
            fsc_d_r <= 1'b0;
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
        end else begin
            dcl_s1_r <= slot_data_clock_in;
            dcl_s2_r <= dcl_s1_r;
            dcl_d_r <= dcl_s2_r;
            fsc_s1_r <= frame_sync_pulse_in;
            fsc_s2_r <= fsc_s1_r;
            fsc_d_r <= fsc_s2_r;
            din_s1_r <= serial_data_in;
            din_s2_r <= din_s1_r;
        end
    end

    // edge detection and position within the frame
    always_comb begin
        dcl_rise = dcl_s2_r & ~dcl_d_r;
        dcl_fall = ~dcl_s2_r & dcl_d_r;
        fsc_rise = fsc_s2_r & ~fsc_d_r;
        // sync rising while clock high starts at once, else next rise
        start = (fsc_rise & dcl_s2_r) | ((state_r == ISLMC_ARMED) & dcl_rise);
        edge_evt = start | ((state_r == ISLMC_FRAME) & dcl_rise);
        idx = start ? 6'h00 : rise_cnt_r + 6'h01;
        // slot is fixed at frame start and used by both directions
        base = (start ? second_bearer_slot_in : slot_sel_r) ? SECOND_SLOT_BASE : FIRST_SLOT_BASE;
        rel = idx - base;
        fall_rel = rise_cnt_r - base;
        rx_word = {rx_shift_r, din_s2_r};
    end

    // compander shared by both directions
    islmc_mulaw u_mulaw (
        .enc_sample_in(tx_sample_in),
        .enc_code_out(enc_code),
        .dec_code_in(rx_word),
        .dec_sample_out(dec_sample)
    );

    // frame sequencer
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= ISLMC_IDLE;
        end else begin
            case (state_r)
                ISLMC_IDLE: begin
                    // wait for a sync pulse
                    if (start) begin
                        state_r <= ISLMC_FRAME;
                    end else if (fsc_rise) begin
                        state_r <= ISLMC_ARMED;
                    end
                end
                ISLMC_ARMED: begin
                    // waiting for the first clock rise
                    if (start) begin
                        state_r <= ISLMC_FRAME;
                    end
                end
                ISLMC_FRAME: begin
                    if (start) begin
                        state_r <= ISLMC_FRAME; // resync on a new pulse
                    end else if (fsc_rise) begin
                        state_r <= ISLMC_ARMED;
                    end else if (dcl_fall & ~confirmed_r & ~fsc_s2_r) begin
                        state_r <= ISLMC_IDLE;
                    end else if (dcl_rise & (idx >= FRAME_END_RISE)) begin
                        state_r <= ISLMC_IDLE;
                    end
                end
                default: begin
                    state_r <= ISLMC_IDLE;
                end
            endcase
        end
    end

    // rise counter, slot latch and sync confirmation
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rise_cnt_r <= 6'h00;
            slot_sel_r <= 1'b0;
            confirmed_r <= 1'b0;
        end else begin
            if (start) begin
                rise_cnt_r <= 6'h00;
                slot_sel_r <= second_bearer_slot_in;
                confirmed_r <= 1'b0;
            end else begin
                if (edge_evt & (rise_cnt_r != RISE_CNT_MAX)) begin
                    rise_cnt_r <= idx;
                end
                // sync is recognised on a falling edge of the data clock
                if ((state_r == ISLMC_FRAME) & dcl_fall & fsc_s2_r) begin
                    confirmed_r <= 1'b1;
                end
            end
        end
    end

    // transmit shifter and output enable
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_shift_r <= '0;
            drive_r <= 1'b0;
            taken_r <= 1'b0;
        end else begin
            taken_r <= 1'b0;
            if (edge_evt & (rel == 6'h00)) begin
                tx_shift_r <= enc_code;
                drive_r <= 1'b1;
                taken_r <= 1'b1;
            end else if (edge_evt & (rel <= SLOT_LAST_OFS) & ~rel[0]) begin
                tx_shift_r <= {tx_shift_r[WORD_BITS-2:0], 1'b0};
            end else if (start | (state_r != ISLMC_FRAME)) begin
                drive_r <= 1'b0;
            end else if (dcl_fall & (fall_rel == SLOT_LAST_OFS)) begin
                drive_r <= 1'b0;
            end else if (dcl_fall & ~confirmed_r & ~fsc_s2_r) begin
                drive_r <= 1'b0;
            end
        end
    end

    // receive shifter, second rise of each bit inside the slot only
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_shift_r <= '0;
            rx_valid_r <= 1'b0;
            rx_code_r <= '1;
            rx_sample_r <= '0;
        end else begin
            rx_valid_r <= 1'b0;
            if (edge_evt & ~start & (rel <= SLOT_LAST_OFS) & rel[0]) begin
                rx_shift_r <= rx_word[WORD_BITS-2:0];
                if (rel == SLOT_LAST_OFS) begin
                    rx_code_r <= rx_word;
                    rx_sample_r <= dec_sample;
                    rx_valid_r <= 1'b1;
                end
            end
        end
    end

    // outputs straight from flops
    always_comb begin
        serial_data_out = tx_shift_r[SIGN_POS];
        serial_data_oe_out = drive_r;
        tx_sample_taken_out = taken_r;
        rx_sample_out = rx_sample_r;
        rx_code_out = rx_code_r;
        rx_valid_out = rx_valid_r;
    end

endmodule : islmc_port

// >>> test/islmc_port_monitor.sv
`timescale 1ns/100ps
// pin checks, 20 core cycles per data clock period
module islmc_port_monitor
    import islmc_pkg::*;
#(parameter int BITS_PER_WORD = WORD_BITS) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic slot_data_clock_in,
    input wire logic frame_sync_pulse_in,
    input wire logic serial_data_in,
    input wire logic second_bearer_slot_in,
    input wire logic [SAMPLE_W-1:0] tx_sample_in,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_out,
    input wire logic tx_sample_taken_out,
    input wire logic [SAMPLE_W-1:0] rx_sample_out,
    input wire logic [WORD_BITS-1:0] rx_code_out,
    input wire logic rx_valid_out
);
    logic [9:0] oe_cnt_r; // cycles with the pin driven
    logic [8:0] gap_cnt_r; // cycles since the driven bit changed
    // drive window length
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) oe_cnt_r <= 10'h000;
        else oe_cnt_r <= serial_data_oe_out ? oe_cnt_r + 10'h001 : 10'h000;
    end
    // spacing of bit changes
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) gap_cnt_r <= 9'h000;
        else gap_cnt_r <= (!serial_data_oe_out || $changed(serial_data_out)) ? 9'h000 : gap_cnt_r + 9'h001;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_drive_go;
        $rose(serial_data_oe_out) ##0 tx_sample_taken_out;
    endsequence
    sequence s_release;
        serial_data_oe_out ##[4:16] !serial_data_oe_out;
    endsequence
    AST_TAKEN_AT_DRIVE: assert property (tx_sample_taken_out |-> s_drive_go)
        else $error("sample taken without drive start");
    AST_BIT_SPACING: assert property (serial_data_oe_out && $past(serial_data_oe_out)
        && $changed(serial_data_out) |-> gap_cnt_r > 9'h01e) else $error("bit changed too early");
    AST_DRIVE_SPAN: assert property ($fell(serial_data_oe_out) |-> oe_cnt_r inside {[10'h127:10'h145]})
        else $error("drive window length wrong");
    AST_VALID_PULSE: assert property (rx_valid_out |=> !rx_valid_out)
        else $error("receive pulse too long");
    AST_VALID_IN_SLOT: assert property (rx_valid_out |-> s_release)
        else $error("word not received in the drive slot");
    AST_RX_HOLD: assert property (!rx_valid_out |-> $stable(rx_code_out) && $stable(rx_sample_out))
        else $error("receive outputs changed without pulse");
    AST_SIGN: assert property (rx_valid_out && rx_code_out[6:0] != 7'h7f
        |-> rx_sample_out[13] == !rx_code_out[7]) else $error("decoded sign wrong");
    AST_TOP_LEVEL: assert property (rx_valid_out && rx_code_out == 8'h80 |-> rx_sample_out == 14'h1f5f)
        else $error("top code decoded wrong");
endmodule : islmc_port_monitor
bind islmc_port islmc_port_monitor #(.BITS_PER_WORD(BITS_PER_WORD)) u_mon (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .slot_data_clock_in(slot_data_clock_in), .frame_sync_pulse_in(frame_sync_pulse_in),
    .serial_data_in(serial_data_in), .second_bearer_slot_in(second_bearer_slot_in), .tx_sample_in(tx_sample_in),
    .serial_data_out(serial_data_out), .serial_data_oe_out(serial_data_oe_out),
    .tx_sample_taken_out(tx_sample_taken_out), .rx_sample_out(rx_sample_out), .rx_code_out(rx_code_out),
    .rx_valid_out(rx_valid_out));

// >>> test/islmc_gci_master.sv
`timescale 1ns/100ps
// gci master: one frame per start, clock still between frames
module islmc_gci_master (
    input wire logic start_in, // frame request
    input wire logic slot_in, // 1 picks second bearer slot
    input wire logic hi_in, // sync rises while clock high
    input wire logic [7:0] word_in, // word sent to the device
    input wire logic line_in, // resolved device output
    output logic dcl_out,
    output logic fsc_out,
    output logic din_out,
    output logic [7:0] cap_out, // word heard from the device
    output logic stb_out // cap_out complete
);
    int b;
    int n;
    initial begin
        {dcl_out, fsc_out, din_out, stb_out, cap_out} = 12'h000;
        forever begin
            @(posedge start_in);
            b = slot_in ? 16 : 0;
            fsc_out = !hi_in;
            #40;
            for (int i = 0; i < 34; i++) begin
                dcl_out = 1'b1;
                #20;
                if (i == 0) fsc_out = 1'b1;
                #60;
                if (i >= b && i < b + 16 && i % 2 == 1) cap_out = {cap_out[6:0], line_in};
                dcl_out = 1'b0;
                stb_out = (i == b + 15);
                #20;
                fsc_out = 1'b0;
                n = i + 1 - b;
                din_out = (n >= 0 && n < 16) ? word_in[7 - n / 2] : !din_out;
                #60;
            end
        end
    end
endmodule : islmc_gci_master

// >>> test/islmc_port_tb_top.sv
`timescale 1ns/100ps
// five frames over both slots and both sync phases
module islmc_port_tb_top
    import islmc_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic start = 1'b0;
    logic sel = 1'b0; // slot select
    logic hi = 1'b0; // sync phase
    logic [7:0] word = 8'h00; // word sent by the master
    logic [13:0] smp = 14'h0000; // sample sent by the device
    logic slot_data_clock, frame_sync_pulse, din, dout, oe, taken, rxv, stb, line_w;
    logic [13:0] rxs;
    logic [7:0] rxc, cap;
    logic [7:0] txq[$]; // expected transmit codes
    logic [7:0] rxq[$]; // expected receive codes
    int miscompares = 0;
    int cmp_count = 0;
    int taken_n = 0; // sample latch pulses seen
    logic [13:0] smp_t[5] = '{14'h1fdf, 14'h2000, 14'h0000, 14'h3f9c, 14'h0000};
    logic [7:0] word_t[5] = '{8'hff, 8'h80, 8'hfe, 8'h00, 8'h00};
    assign line_w = oe ? dout : 1'b1; // pulled up while released
    initial forever #4 core_clk_in = ~core_clk_in;
    islmc_port dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .slot_data_clock_in(slot_data_clock),
        .frame_sync_pulse_in(frame_sync_pulse), .serial_data_in(din), .second_bearer_slot_in(sel), .tx_sample_in(smp),
        .serial_data_out(dout), .serial_data_oe_out(oe), .tx_sample_taken_out(taken),
        .rx_sample_out(rxs), .rx_code_out(rxc), .rx_valid_out(rxv));
    islmc_gci_master u_gci (.start_in(start), .slot_in(sel), .hi_in(hi), .word_in(word), .line_in(line_w),
        .dcl_out(slot_data_clock), .fsc_out(frame_sync_pulse), .din_out(din), .cap_out(cap), .stb_out(stb));
    // expected code from the chord and step table
    function automatic logic [7:0] enc(input logic [13:0] x);
        logic [13:0] m;
        logic [2:0] c;
        int b;
        m = x[13] ? -x : x;
        b = m + 33;
        if (b > 8191) b = 8191;
        c = 3'h0;
        for (int j = 0; j < 8; j++) if (b[j + 5]) c = 3'(j);
        return {~x[13], ~c, ~b[c + 4 -: 4]};
    endfunction : enc
    // expected decode level
    function automatic logic [13:0] dec(input logic [7:0] w);
        int v;
        v = ((2 * (w[3:0] ^ 4'hf) + 33) << (w[6:4] ^ 3'h7)) - 33;
        return w[7] ? 14'(v) : 14'(-v);
    endfunction : dec
    task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // eight-bit code compare
    task automatic chk_code(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_code
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    // receive result against the oldest note, looked at mid-cycle
    always @(negedge core_clk_in) begin
        if (taken === 1'b1) begin
            taken_n++;
        end
        if (rxv === 1'b1) begin
            chk_code("rx_code", rxq[0], rxc);
            chk("rx_sample", dec(rxq[0]), rxs);
            rxq.delete(0);
        end
    end
    // transmit word heard by the master
    always @(posedge stb) begin
        chk_code("tx_code", txq[0], cap);
        txq.delete(0);
    end
    initial begin
        void'($urandom(32'h2e38_7747));
        smp_t[4] = 14'($urandom());
        word_t[4] = 8'($urandom());
        repeat (3) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        for (int f = 0; f < 5; f++) begin
            @(posedge core_clk_in);
            #1;
            {hi, sel} = 2'(f);
            smp = smp_t[f];
            word = word_t[f];
            txq.push_back(enc(smp_t[f]));
            rxq.push_back(word_t[f]);
            start = 1'b1;
            @(posedge core_clk_in);
            #1 start = 1'b0;
            repeat (15623) @(posedge core_clk_in);
            $display("frame %0d done", f);
        end
        chk("taken", 14'h0005, 14'(taken_n));
        chk("pending", 14'h0000, 14'(txq.size() + rxq.size()));
        test_done();
    end
    // hang guard
    initial begin
        #700000;
        miscompares++;
        test_done();
    end
endmodule : islmc_port_tb_top
